// File: rtl/pss_pkg.sv
// Constants of the scan supervisor: register map, fields, timing.
// Assumes a 50 MHz system clock.
package pss_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROG_MASK = 8'h04;
  localparam logic [7:0] OFS_INT_EN = 8'h08;
  localparam logic [7:0] OFS_WDT_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EXP_ERR = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_EDIT = 8'h20;
  localparam logic [7:0] OFS_PERIOD_BASE = 8'h40;

  // ==========================================================
  // Fields
  localparam int CTRL_GEI_BIT = 0;
  localparam int EDIT_OPEN_BIT = 8;
  localparam int ST_WDT_BIT = 0;
  localparam int ST_MISSING_BIT = 1;
  localparam int ST_UV_BIT = 2;
  localparam int ST_REMOTE_BIT = 3;
  localparam int ST_HALT_BIT = 4;
  localparam int ST_CODE_LSB = 16;
  // Event bits of IRQ_STAT / IRQ_MASK
  localparam int EV_WDT = 0;
  localparam int EV_MISSING = 1;
  localparam int EV_UV = 2;
  localparam int EV_EXP = 3;
  localparam int EV_NOPROG = 4;
  localparam int EV_EDIT = 5;
  localparam int EV_CALL = 6;
  localparam int EV_TERM = 7;
  localparam int N_EV = 8;

  // ==========================================================
  // Sizes, codes, reset values
  localparam int N_INT = 15;
  localparam int N_EXP = 11;
  localparam int SUB_MAX = 128;
  localparam logic [15:0] ERR_MODULE_MISSING = 16'h0308;
  localparam logic [15:0] PERIOD_RESET = 16'h0001;
  localparam logic [12:0] WDT_MIN_MS = 13'd10;
  localparam logic [12:0] WDT_MAX_MS = 13'd6000;
  localparam logic [12:0] WDT_RESET_MS = 13'd200;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int PERIOD_UNIT_MS = 10;

  // Program kinds on the execution port
  localparam logic [2:0] KIND_COLD = 3'h0;
  localparam logic [2:0] KIND_HOT = 3'h1;
  localparam logic [2:0] KIND_SCAN = 3'h2;
  localparam logic [2:0] KIND_SUB = 3'h3;
  localparam logic [2:0] KIND_INT = 3'h4;

  typedef enum logic [7:0] {
    ST_HALT = 8'h01,
    ST_COLD = 8'h02,
    ST_HOT = 8'h04,
    ST_INPUT = 8'h08,
    ST_SOLVE = 8'h10,
    ST_SUB = 8'h20,
    ST_INTR = 8'h40,
    ST_OUTPUT = 8'h80
  } pss_state_t;

endpackage : pss_pkg

// File: rtl/pss_scan_supervisor.sv
// Scan supervisor: scan sequencing, init programs, periodic interrupts,
// scan watchdog, module/expansion/supply monitoring.
// Assumes an execution engine on the same clock and pins from outside.
//
// Operation
// R1 - Repeat input, solve, output scan forever
// R2 - Scan programs run in ascending ID; need one
// R3 - Subroutine call runs, then caller resumes
// R4 - Max 128 subroutines; one online edit
// R5 - Cold init before first scan program
// R6 - Power return in run: hot init, restart
// R7 - Init ends on init end; scan on end
// R8 - Fifteen periodic interrupts, lower ID first
// R9 - Each interrupt has priority and period
// R10 - Interrupts need global and individual enable
// R11 - Watchdog limit 10 ms to 6 s
// R12 - Overrun: fault, remote halt, set flag
// R13 - Fault held until power cycle or halt
// R14 - Missing module: code 0x0308, remote halt
// R15 - Expansion error sets that module's bit
// R16 - Supply under 10 V: stop, outputs off
// R17 - Watchdog count restarts each scan
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps

module pss_scan_supervisor #(
  parameter int MS_CYCLES = pss_pkg::MS_CYCLES,
  parameter int N_PROG = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic run_switch_pin,
  input wire logic module_missing_pin,
  input wire logic supply_low_pin,
  input wire logic hot_restart_strap,
  output logic exec_start,
  output logic [2:0] exec_kind,
  output logic [7:0] exec_prog_id,
  output logic [7:0] exec_sub_num,
  output logic exec_resume,
  input wire logic exec_done,
  input wire logic exec_init_end,
  input wire logic call_req,
  input wire logic [7:0] call_prog_id,
  input wire logic [7:0] call_sub_num,
  input wire logic exp_err_valid,
  input wire logic [3:0] exp_err_index,
  output logic input_latch,
  output logic output_update,
  output logic outputs_off,
  output logic cpu_halt,
  output logic remote_halt,
  output logic watchdog_fault_flag,
  output logic [pss_pkg::N_EXP-1:0] expansion_error_flags,
  output logic [15:0] error_code,
  output logic irq
);

  // ==========================================================
  // Pin synchronisers: change counts once stages 2 and 3 agree
  logic [2:0] s1_q, s2_q, s3_q;
  logic [2:0] pin_q;
  logic run_sw, missing, uv;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      pin_q <= 3'h0;
    end
    else
    begin
      s1_q <= {supply_low_pin, module_missing_pin, run_switch_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 3; i++)
        if (s2_q[i] == s3_q[i])
          pin_q[i] <= s3_q[i];
    end
  end
  assign run_sw = pin_q[0];
  assign missing = pin_q[1];
  assign uv = pin_q[2];

  // ==========================================================
  // Timebase: millisecond and 10 ms ticks
  logic [$clog2(MS_CYCLES)-1:0] pre_q;
  logic [3:0] ms10_q;
  logic ms_tick, tick10;
  assign ms_tick = (pre_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  assign tick10 = ms_tick && (ms10_q == 4'(pss_pkg::PERIOD_UNIT_MS - 1));

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_q <= '0;
      ms10_q <= 4'h0;
    end
    else
    begin
      pre_q <= ms_tick ? '0 : pre_q + 1'b1;
      if (tick10)
        ms10_q <= 4'h0;
      else if (ms_tick)
        ms10_q <= ms10_q + 4'h1;
    end
  end

  // ==========================================================
  // Software registers
  logic gei_q;
  logic [N_PROG-1:0] prog_mask_q;
  logic [pss_pkg::N_INT-1:0] int_en_q;
  logic [12:0] wdt_limit_q;
  logic [pss_pkg::N_EV-1:0] irq_mask_q;
  logic [15:0] period_q [pss_pkg::N_INT];
  logic [3:0] prio_q [pss_pkg::N_INT];
  logic [12:0] lim_in;
  logic per_wr;
  logic [3:0] per_idx;
  assign per_idx = reg_addr[5:2];
  assign per_wr = reg_wr && reg_addr[7:6] == pss_pkg::OFS_PERIOD_BASE[7:6]
    && per_idx < 4'(pss_pkg::N_INT);
  // Clamp on the full word so large values do not wrap
  assign lim_in = reg_wdata < 32'(pss_pkg::WDT_MIN_MS) ? pss_pkg::WDT_MIN_MS
    : reg_wdata > 32'(pss_pkg::WDT_MAX_MS) ? pss_pkg::WDT_MAX_MS
    : reg_wdata[12:0];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gei_q <= 1'b0;
      prog_mask_q <= '0;
      int_en_q <= '0;
      wdt_limit_q <= pss_pkg::WDT_RESET_MS;
      irq_mask_q <= '0;
      for (int i = 0; i < pss_pkg::N_INT; i++)
      begin
        period_q[i] <= pss_pkg::PERIOD_RESET;
        prio_q[i] <= 4'h0;
      end
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        pss_pkg::OFS_CTRL: gei_q <= reg_wdata[pss_pkg::CTRL_GEI_BIT];
        pss_pkg::OFS_PROG_MASK: prog_mask_q <= reg_wdata[N_PROG-1:0];
        pss_pkg::OFS_INT_EN: int_en_q <= reg_wdata[pss_pkg::N_INT-1:0];
        pss_pkg::OFS_WDT_LIMIT: wdt_limit_q <= lim_in; // [R11]
        pss_pkg::OFS_IRQ_MASK: irq_mask_q <= reg_wdata[pss_pkg::N_EV-1:0];
        default:
        begin
          if (per_wr)
          begin
            // Period in 10 ms units, zero taken as one unit [R9]
            period_q[per_idx] <= reg_wdata[15:0] == 16'h0 ?
              pss_pkg::PERIOD_RESET : reg_wdata[15:0];
            prio_q[per_idx] <= reg_wdata[19:16];
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Periodic interrupt timers, one per interrupt program
  logic [pss_pkg::N_INT-1:0] pend_q, clr_pend;
  genvar g;
  generate
    for (g = 0; g < pss_pkg::N_INT; g++)
    begin : g_int
      logic [15:0] cnt_q;
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          cnt_q <= pss_pkg::PERIOD_RESET;
          pend_q[g] <= 1'b0;
        end
        else if (!(gei_q && int_en_q[g]))
        begin
          cnt_q <= period_q[g]; // [R10]
          pend_q[g] <= 1'b0;
        end
        else
        begin
          if (tick10)
            cnt_q <= cnt_q <= 16'h1 ? period_q[g] : cnt_q - 16'h1; // [R9]
          if (tick10 && cnt_q <= 16'h1)
            pend_q[g] <= 1'b1;
          else if (clr_pend[g])
            pend_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Lowest pending ID wins [R8]
  logic int_due;
  logic [3:0] int_sel;
  always_comb
  begin
    int_due = 1'b0;
    int_sel = 4'h0;
    for (int i = pss_pkg::N_INT - 1; i >= 0; i--)
      if (pend_q[i] && gei_q && int_en_q[i])
      begin
        int_due = 1'b1;
        int_sel = 4'(i);
      end
  end

  // Next registered scan program above the current one [R2]
  function automatic logic [8:0] next_prog(input logic [N_PROG-1:0] mask,
    input logic [7:0] cur, input logic first);
    logic [8:0] r;
    r = 9'h0;
    for (int i = N_PROG - 1; i >= 0; i--)
      if (mask[i] && (first || 8'(i) > cur))
        r = {1'b1, 8'(i)};
    return r;
  endfunction : next_prog

  // ==========================================================
  // Scan sequencer
  pss_pkg::pss_state_t state_q;
  logic [7:0] cur_id_q;
  logic hot_q, hot_seen_q, launched_q;
  logic wdt_fault_q, miss_fault_q, wdt_over;
  logic [12:0] wdt_ms_q;
  logic ev_noprog, ev_call, ev_term;
  logic [8:0] nxt_first, nxt_after;
  logic stop;
  assign nxt_first = next_prog(prog_mask_q, 8'h0, 1'b1);
  assign nxt_after = next_prog(prog_mask_q, cur_id_q, 1'b0);
  assign stop = !run_sw || wdt_fault_q || miss_fault_q || uv;
  assign wdt_over = wdt_ms_q > wdt_limit_q;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= pss_pkg::ST_HALT;
      cur_id_q <= 8'h0;
      hot_q <= 1'b0;
      hot_seen_q <= 1'b0;
      launched_q <= 1'b0;
      exec_start <= 1'b0;
      exec_kind <= pss_pkg::KIND_COLD;
      exec_prog_id <= 8'h0;
      exec_sub_num <= 8'h0;
      exec_resume <= 1'b0;
      input_latch <= 1'b0;
      output_update <= 1'b0;
      ev_noprog <= 1'b0;
      ev_call <= 1'b0;
      ev_term <= 1'b0;
      clr_pend <= '0;
    end
    else
    begin
      exec_start <= 1'b0;
      exec_resume <= 1'b0;
      input_latch <= 1'b0;
      output_update <= 1'b0;
      ev_noprog <= 1'b0;
      ev_call <= 1'b0;
      ev_term <= 1'b0;
      clr_pend <= '0;
      // Strap caught once after release
      if (!launched_q)
      begin
        launched_q <= 1'b1;
        hot_q <= hot_restart_strap;
      end
      if (stop)
      begin
        // Supply loss while running asks for a hot restart [R6]
        if (uv && state_q != pss_pkg::ST_HALT)
          hot_q <= 1'b1;
        state_q <= pss_pkg::ST_HALT; // [R12] [R14] [R16]
      end
      else
      begin
        case (state_q)
          pss_pkg::ST_HALT:
          begin
            if (launched_q)
            begin
              state_q <= hot_q ? pss_pkg::ST_HOT : pss_pkg::ST_COLD; // [R5]
              exec_kind <= hot_q ? pss_pkg::KIND_HOT : pss_pkg::KIND_COLD;
              exec_prog_id <= 8'h0;
              exec_start <= 1'b1;
              hot_q <= 1'b0;
              hot_seen_q <= hot_q; // [R6]
            end
          end
          pss_pkg::ST_COLD, pss_pkg::ST_HOT:
          begin
            if (exec_done)
            begin
              if (!exec_init_end)
                ev_term <= 1'b1; // [R7]
              else if (!nxt_first[8])
              begin
                ev_noprog <= 1'b1; // [R2]
                state_q <= pss_pkg::ST_HALT;
                hot_q <= hot_seen_q;
              end
              else
                state_q <= pss_pkg::ST_INPUT; // [R5] [R6]
            end
          end
          pss_pkg::ST_INPUT:
          begin
            input_latch <= 1'b1; // [R1]
            if (nxt_first[8])
            begin
              cur_id_q <= nxt_first[7:0];
              exec_prog_id <= nxt_first[7:0];
              exec_kind <= pss_pkg::KIND_SCAN;
              exec_start <= 1'b1;
              state_q <= pss_pkg::ST_SOLVE;
            end
            else
            begin
              ev_noprog <= 1'b1; // [R2]
              state_q <= pss_pkg::ST_OUTPUT;
            end
          end
          pss_pkg::ST_SOLVE:
          begin
            if (call_req)
            begin
              if ({1'b0, call_sub_num} >= 9'(pss_pkg::SUB_MAX))
                ev_call <= 1'b1; // [R4]
              else
              begin
                exec_kind <= pss_pkg::KIND_SUB; // [R3]
                exec_prog_id <= call_prog_id;
                exec_sub_num <= call_sub_num;
                exec_start <= 1'b1;
                state_q <= pss_pkg::ST_SUB;
              end
            end
            else if (exec_done)
            begin
              if (exec_init_end)
                ev_term <= 1'b1; // [R7]
              if (int_due)
              begin
                clr_pend[int_sel] <= 1'b1; // [R8] [R10]
                exec_kind <= pss_pkg::KIND_INT;
                exec_prog_id <= {4'h0, int_sel};
                exec_start <= 1'b1;
                state_q <= pss_pkg::ST_INTR;
              end
              else if (nxt_after[8])
              begin
                cur_id_q <= nxt_after[7:0]; // [R2]
                exec_kind <= pss_pkg::KIND_SCAN;
                exec_prog_id <= nxt_after[7:0];
                exec_start <= 1'b1;
              end
              else
                state_q <= pss_pkg::ST_OUTPUT;
            end
          end
          pss_pkg::ST_SUB:
          begin
            if (exec_done)
            begin
              exec_resume <= 1'b1; // [R3]
              exec_kind <= pss_pkg::KIND_SCAN;
              exec_prog_id <= cur_id_q;
              state_q <= pss_pkg::ST_SOLVE;
            end
          end
          pss_pkg::ST_INTR:
          begin
            if (exec_done)
            begin
              if (nxt_after[8])
              begin
                cur_id_q <= nxt_after[7:0];
                exec_kind <= pss_pkg::KIND_SCAN;
                exec_prog_id <= nxt_after[7:0];
                exec_start <= 1'b1;
                state_q <= pss_pkg::ST_SOLVE;
              end
              else
                state_q <= pss_pkg::ST_OUTPUT;
            end
          end
          pss_pkg::ST_OUTPUT:
          begin
            output_update <= 1'b1; // [R1]
            state_q <= pss_pkg::ST_INPUT;
          end
          default: state_q <= pss_pkg::ST_HALT;
        endcase
      end
    end
  end

  // ==========================================================
  // Scan watchdog and halt faults
  logic scanning;
  assign scanning = state_q == pss_pkg::ST_SOLVE
    || state_q == pss_pkg::ST_SUB || state_q == pss_pkg::ST_INTR;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wdt_ms_q <= 13'h0;
      wdt_fault_q <= 1'b0;
      miss_fault_q <= 1'b0;
    end
    else
    begin
      if (state_q == pss_pkg::ST_INPUT)
        wdt_ms_q <= 13'h0; // [R17]
      else if (scanning && ms_tick && !wdt_over)
        wdt_ms_q <= wdt_ms_q + 13'h1;
      if (scanning && wdt_over)
        wdt_fault_q <= 1'b1; // [R12]
      else if (!run_sw)
        wdt_fault_q <= 1'b0; // [R13]
      if (missing)
        miss_fault_q <= 1'b1; // [R14]
      else if (!run_sw)
        miss_fault_q <= 1'b0;
    end
  end

  // ==========================================================
  // Expansion errors, online edit, interrupt status
  logic edit_open_q, ev_edit;
  logic [7:0] edit_num_q;
  logic [pss_pkg::N_EV-1:0] irq_stat_q, ev_set;
  logic [31:0] w1c;
  logic ev_wdt, ev_miss, ev_uv, wdt_d_q, miss_d_q, uv_d_q;
  assign ev_edit = reg_wr && reg_addr == pss_pkg::OFS_EDIT
    && reg_wdata[pss_pkg::EDIT_OPEN_BIT] && edit_open_q
    && reg_wdata[7:0] != edit_num_q; // [R4]
  assign ev_wdt = wdt_fault_q && !wdt_d_q;
  assign ev_miss = miss_fault_q && !miss_d_q;
  assign ev_uv = uv && !uv_d_q;
  assign ev_set = {ev_term, ev_call, ev_edit, ev_noprog, exp_err_valid,
    ev_uv, ev_miss, ev_wdt};
  assign w1c = reg_wr ? reg_wdata : 32'h0;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      expansion_error_flags <= '0;
      edit_open_q <= 1'b0;
      edit_num_q <= 8'h0;
      irq_stat_q <= '0;
      wdt_d_q <= 1'b0;
      miss_d_q <= 1'b0;
      uv_d_q <= 1'b0;
    end
    else
    begin
      wdt_d_q <= wdt_fault_q;
      miss_d_q <= miss_fault_q;
      uv_d_q <= uv;
      for (int i = 0; i < pss_pkg::N_EXP; i++)
        if (exp_err_valid && exp_err_index == 4'(i))
          expansion_error_flags[i] <= 1'b1; // [R15]
        else if (reg_addr == pss_pkg::OFS_EXP_ERR && w1c[i])
          expansion_error_flags[i] <= 1'b0;
      for (int i = 0; i < pss_pkg::N_EV; i++)
        if (ev_set[i])
          irq_stat_q[i] <= 1'b1;
        else if (reg_addr == pss_pkg::OFS_IRQ_STAT && w1c[i])
          irq_stat_q[i] <= 1'b0;
      if (reg_wr && reg_addr == pss_pkg::OFS_EDIT)
      begin
        if (!reg_wdata[pss_pkg::EDIT_OPEN_BIT])
          edit_open_q <= 1'b0;
        else if (!edit_open_q)
        begin
          edit_open_q <= 1'b1;
          edit_num_q <= reg_wdata[7:0];
        end
      end
    end
  end

  // ==========================================================
  // Outputs and read port
  assign irq = |(irq_stat_q & irq_mask_q);
  assign cpu_halt = state_q == pss_pkg::ST_HALT;
  assign outputs_off = uv || cpu_halt; // [R16]
  assign remote_halt = wdt_fault_q || miss_fault_q;
  assign watchdog_fault_flag = wdt_fault_q; // [R12]
  assign error_code = miss_fault_q ? pss_pkg::ERR_MODULE_MISSING : 16'h0;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 32'h0;
    else if (!reg_rd)
      reg_rdata <= 32'h0;
    else
    begin
      case (reg_addr)
        pss_pkg::OFS_CTRL: reg_rdata <= {31'h0, gei_q};
        pss_pkg::OFS_PROG_MASK: reg_rdata <= 32'(prog_mask_q);
        pss_pkg::OFS_INT_EN: reg_rdata <= 32'(int_en_q);
        pss_pkg::OFS_WDT_LIMIT: reg_rdata <= {19'h0, wdt_limit_q};
        pss_pkg::OFS_STATUS: reg_rdata <= {error_code, 11'h0, cpu_halt,
          remote_halt, uv, miss_fault_q, wdt_fault_q};
        pss_pkg::OFS_EXP_ERR: reg_rdata <= 32'(expansion_error_flags);
        pss_pkg::OFS_IRQ_STAT: reg_rdata <= 32'(irq_stat_q);
        pss_pkg::OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask_q);
        pss_pkg::OFS_EDIT: reg_rdata <= {23'h0, edit_open_q, edit_num_q};
        default: reg_rdata <= per_wr || (reg_addr[7:6] == 2'h1
          && per_idx < 4'(pss_pkg::N_INT)) ?
          {12'h0, prio_q[per_idx], period_q[per_idx]} : 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Checks
  out_then_in_a: assert property ( // [R1]
    @(posedge clk_sys) disable iff (!reset_n)
    state_q == pss_pkg::ST_OUTPUT |=> state_q == pss_pkg::ST_INPUT
      || state_q == pss_pkg::ST_HALT)
    else $error("output phase not followed by input phase");
  sub_resume_a: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!reset_n)
    state_q == pss_pkg::ST_SUB && exec_done && !stop
      |=> exec_resume && state_q == pss_pkg::ST_SOLVE)
    else $error("caller not resumed after subroutine");
  int_gate_a: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!reset_n)
    exec_start && exec_kind == pss_pkg::KIND_INT
      |-> $past(gei_q)
      && (($past(int_en_q) >> exec_prog_id[3:0]) & 15'h1) != 15'h0)
    else $error("interrupt started without enables");
  wdt_restart_a: assert property ( // [R17]
    @(posedge clk_sys) disable iff (!reset_n)
    state_q == pss_pkg::ST_INPUT |=> wdt_ms_q == 13'h0)
    else $error("watchdog count not restarted");
  wdt_fault_a: assert property ( // [R12]
    @(posedge clk_sys) disable iff (!reset_n)
    scanning && wdt_over |=> watchdog_fault_flag ##1 cpu_halt)
    else $error("watchdog overrun did not halt");
  wdt_hold_a: assert property ( // [R13]
    @(posedge clk_sys) disable iff (!reset_n)
    wdt_fault_q && run_sw |=> wdt_fault_q)
    else $error("watchdog fault cleared while in run");
  missing_code_a: assert property ( // [R14]
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(miss_fault_q) |-> error_code == pss_pkg::ERR_MODULE_MISSING
      && remote_halt ##1 cpu_halt)
    else $error("missing module not reported");
  uv_off_a: assert property ( // [R16]
    @(posedge clk_sys) disable iff (!reset_n)
    uv |-> outputs_off
      ##1 cpu_halt && !exec_start && !output_update)
    else $error("outputs on during low supply");

endmodule : pss_scan_supervisor

// File: sim/tb_top.sv
// Self-checking bench for the scan supervisor.
// Assumes the design package is compiled first; one 50 MHz clock.
`timescale 1ns/10ps

module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic run_switch_pin = 1'b0, module_missing_pin = 1'b0;
  logic supply_low_pin = 1'b0, hot_restart_strap = 1'b0;
  logic exec_start, exec_resume, exec_done = 1'b0, exec_init_end = 1'b0;
  logic [2:0] exec_kind;
  logic [7:0] exec_prog_id, exec_sub_num;
  logic call_req = 1'b0, exp_err_valid = 1'b0;
  logic [7:0] call_prog_id = 8'h00, call_sub_num = 8'h00;
  logic [3:0] exp_err_index = 4'h0;
  logic input_latch, output_update, outputs_off, cpu_halt, remote_halt;
  logic watchdog_fault_flag, irq;
  logic [pss_pkg::N_EXP-1:0] expansion_error_flags;
  logic [15:0] error_code;
  int failures = 0;
  int checked = 0;

  pss_scan_supervisor #(.MS_CYCLES(10), .N_PROG(32)) pss_scan_supervisor_i (
    .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .run_switch_pin, .module_missing_pin, .supply_low_pin,
    .hot_restart_strap, .exec_start, .exec_kind, .exec_prog_id,
    .exec_sub_num, .exec_resume, .exec_done, .exec_init_end, .call_req,
    .call_prog_id, .call_sub_num, .exp_err_valid, .exp_err_index,
    .input_latch, .output_update, .outputs_off, .cpu_halt, .remote_halt,
    .watchdog_fault_flag, .expansion_error_flags, .error_code, .irq);

  always #10 clk_sys = ~clk_sys;

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Waits for the next program start, bounded
  task wait_start;
    int n;
    for (n = 0; n < 300; n++)
    begin
      #1;
      if (exec_start === 1'b1)
        break;
      @(posedge clk_sys);
    end
    check(exec_start, 1'b1);
  endtask : wait_start

  task do_call(input logic [7:0] num);
    @(posedge clk_sys);
    call_req <= 1'b1;
    call_prog_id <= 8'h04;
    call_sub_num <= num;
    @(posedge clk_sys);
    call_req <= 1'b0;
  endtask : do_call

  task finish_prog(input logic init);
    @(posedge clk_sys);
    exec_done <= 1'b1;
    exec_init_end <= init;
    @(posedge clk_sys);
    exec_done <= 1'b0;
  endtask : finish_prog

  task test_regs;
    logic [31:0] d;
    rd(pss_pkg::OFS_WDT_LIMIT, d);
    check(d, 32'h0000_00c8);
    wr(pss_pkg::OFS_WDT_LIMIT, 32'h0000_0005);
    rd(pss_pkg::OFS_WDT_LIMIT, d);
    check(d, 32'h0000_000a);
    rd(8'h3c, d);
    check(d, 32'h0);
    $display("test regs done");
  endtask : test_regs

  task test_scan_and_watchdog;
    int n;
    wr(pss_pkg::OFS_PROG_MASK, 32'h0000_000a);
    run_switch_pin <= 1'b1;
    wait_start();
    check(exec_kind, pss_pkg::KIND_COLD);
    finish_prog(1'b1);
    wait_start();
    check(input_latch, 1'b1);
    check(exec_kind, pss_pkg::KIND_SCAN);
    check(exec_prog_id, 8'h01);
    finish_prog(1'b0);
    wait_start();
    check(exec_prog_id, 8'h03);
    // Program 3 never ends: 10 ms limit at 10 cycles per ms
    for (n = 0; n < 300 && watchdog_fault_flag !== 1'b1; n++)
      @(posedge clk_sys);
    check(n > 90 && n < 200, 1'b1);
    repeat (3) @(posedge clk_sys);
    check(watchdog_fault_flag, 1'b1);
    check(remote_halt, 1'b1);
    check(outputs_off, 1'b1);
    run_switch_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check(watchdog_fault_flag, 1'b0);
    $display("test scan and watchdog done");
  endtask : test_scan_and_watchdog

  task test_call_int;
    logic [31:0] d;
    wr(pss_pkg::OFS_WDT_LIMIT, 32'h0000_2000);
    rd(pss_pkg::OFS_WDT_LIMIT, d);
    check(d, 32'h0000_1770);
    wr(pss_pkg::OFS_CTRL, 32'h0000_0001);
    wr(pss_pkg::OFS_INT_EN, 32'h0000_0001);
    wr(pss_pkg::OFS_PERIOD_BASE, 32'h0000_0001);
    run_switch_pin <= 1'b1;
    wait_start();
    check(exec_kind, pss_pkg::KIND_COLD);
    finish_prog(1'b1);
    wait_start();
    check(exec_prog_id, 8'h01);
    do_call(8'h01);
    wait_start();
    check(exec_kind, pss_pkg::KIND_SUB);
    check({exec_prog_id, exec_sub_num}, 16'h0401);
    finish_prog(1'b0);
    #1 check(exec_resume, 1'b1);
    do_call(8'h80);
    rd(pss_pkg::OFS_IRQ_STAT, d);
    check(d[pss_pkg::EV_CALL], 1'b1);
    // Period of one unit: due within 100 cycles
    repeat (110) @(posedge clk_sys);
    finish_prog(1'b0);
    wait_start();
    check(exec_kind, pss_pkg::KIND_INT);
    check(exec_prog_id, 8'h00);
    wr(pss_pkg::OFS_INT_EN, 32'h0);
    finish_prog(1'b0);
    wait_start();
    check(exec_prog_id, 8'h03);
    finish_prog(1'b0);
    @(posedge clk_sys);
    #1 check(output_update, 1'b1);
    @(posedge clk_sys);
    run_switch_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(cpu_halt, 1'b1);
    $display("test call and interrupt done");
  endtask : test_call_int

  task test_faults;
    logic [31:0] d;
    wr(pss_pkg::OFS_IRQ_MASK, 32'h0000_0008);
    @(posedge clk_sys);
    exp_err_valid <= 1'b1;
    exp_err_index <= 4'ha;
    @(posedge clk_sys);
    exp_err_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(expansion_error_flags, 11'h400);
    check(irq, 1'b1);
    wr(pss_pkg::OFS_IRQ_STAT, 32'h0000_0008);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b0);
    module_missing_pin <= 1'b1;
    supply_low_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(error_code, 16'h0308);
    check(remote_halt, 1'b1);
    rd(pss_pkg::OFS_STATUS, d);
    check(d[pss_pkg::ST_UV_BIT], 1'b1);
    check(outputs_off, 1'b1);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1 check(remote_halt, 1'b0);
    $display("test faults done");
  endtask : test_faults

  task report_and_stop;
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_regs();
    test_scan_and_watchdog();
    test_call_int();
    test_faults();
    report_and_stop();
  end

  initial
  begin
    #200us;
    failures++;
    report_and_stop();
  end
endmodule : tb_top
